// file: epc_defs.svh
// Constants for the nonvolatile program and erase controller
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH
`define EPC_WORDS         16
`define EPC_ADDR_W        6
`define EPC_BLOCKS        4
`define EPC_BLK_W         2
`define EPC_ERASED_WORD   32'hFFFFFFFF
`define EPC_SIZE_BYTES    32'h00000040
`define EPC_PROG_NS       500
`define EPC_CLK_NS        100
`define EPC_PROG_CYC      ((`EPC_PROG_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_ERASE_CYC     (`EPC_WORDS)
`define EPC_ST_INVPL_BIT  0
`define EPC_ST_WRBUSY_BIT 1
`define EPC_ST_NOPERM_BIT 2
`define EPC_ST_COPY_BIT   3
`define EPC_ST_ERASE_BIT  4
`define EPC_ST_ACTIVE_BIT 5
`define EPC_PROT_RESET    3'h0
`endif

// file: epc_pkg.sv
// Types for the nonvolatile program and erase controller
package epc_pkg;
  typedef enum logic [1:0]
  {
    EPC_IDLE  = 2'b00,
    EPC_PROG  = 2'b01,
    EPC_ERASE = 2'b10
  } epc_state_t;
endpackage

// file: epc_block_guard.sv
// Effective protection check for one block
`timescale 1ns/1ns
module epc_block_guard
(
  input  wire logic [2:0] blk0Prot,
  input  wire logic [2:0] ownProt,
  input  wire logic       isBlock0,
  input  wire logic       blk0Locked,
  input  wire logic       superMode,
  output logic            canRead,
  output logic            canWrite
);
  // Bit 0 read-only, bit 1 no access, bit 2 supervisor only
  logic [2:0] eff;
  always_comb
  begin
    eff = isBlock0 ? blk0Prot : (blk0Prot | ownProt); // [RULE_15]
    canRead  = !eff[1] && !(eff[2] && !superMode) && (isBlock0 || !blk0Locked); // [RULE_14]
    canWrite = canRead && !eff[0];
  end
endmodule

// file: eeprom_program_erase_control.sv
// Program, erase, read and interrupt logic of the nonvolatile word array
//
// Function
// [RULE_01] Completion interrupt raised whenever any write or erase finishes.
// [RULE_02] Interrupt drives the vector shared with flash; flash enable also gates it.
// [RULE_03] Raw and masked interrupt status both readable.
// [RULE_04] Interrupt stays set until software clears it.
// [RULE_05] Mass erase leaves every word at all ones.
// [RULE_06] Mass erase clears protections and passwords; everything accessible.
// [RULE_07] Software gives word-aligned byte addresses.
// [RULE_08] Software gives byte counts that are multiples of four.
// [RULE_09] Single-word write starts at once; completion reported by interrupt.
// [RULE_10] Working, copy and erase flags show activity, not errors.
// [RULE_11] Status zero on clean finish, else combination of flags.
// [RULE_12] Total capacity in bytes readable.
// [RULE_13] Consecutive words readable from an aligned start address.
// [RULE_14] Block 0 locked refuses every other block.
// [RULE_15] Effective protection of block n is block 0 OR own flags.
// [RULE_16] Forbidden write sets no-permission and leaves array unchanged.
`timescale 1ns/1ns
`include "epc_defs.svh"
module eeprom_program_erase_control
  import epc_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   superMode,
  input  wire logic                   progStart,
  input  wire logic [`EPC_ADDR_W+1:0] progAddr,
  input  wire logic [31:0]            progData,
  input  wire logic                   eraseStart,
  input  wire logic                   readStart,
  input  wire logic [`EPC_ADDR_W+1:0] readAddr,
  input  wire logic [`EPC_ADDR_W+1:0] readCount,
  input  wire logic                   protWrite,
  input  wire logic [`EPC_BLK_W-1:0]  protBlock,
  input  wire logic [2:0]             protValue,
  input  wire logic                   lockWrite,
  input  wire logic [`EPC_BLK_W-1:0]  lockBlock,
  input  wire logic                   lockValue,
  input  wire logic                   intEnableSet,
  input  wire logic                   intEnableClr,
  input  wire logic                   flashIntEnable,
  input  wire logic                   intClear,
  output logic [31:0]                 readData,
  output logic                        readValid,
  output logic [5:0]                  opStatus,
  output logic                        intRaw,
  output logic                        intMasked,
  output logic                        flashVectorIrq,
  output logic [31:0]                 sizeBytes,
  output logic                        invalid_protect_level_flag,
  output logic                        write_busy_flag,
  output logic                        no_permission_flag,
  output logic                        copy_in_progress_flag,
  output logic                        erase_in_progress_flag,
  output logic                        operation_active_flag
);
  localparam int PROG_CYC  = `EPC_PROG_CYC;
  localparam int ERASE_CYC = `EPC_ERASE_CYC;
  localparam int WORD_W    = `EPC_ADDR_W - `EPC_BLK_W;

  epc_state_t              state;
  logic [31:0]             mem [`EPC_WORDS];
  logic [2:0]              prot [`EPC_BLOCKS];
  logic [`EPC_BLOCKS-1:0]  locked;
  logic [`EPC_BLOCKS-1:0]  wrOk;
  logic [`EPC_BLOCKS-1:0]  rdOk;
  logic [7:0]              timer;
  logic [`EPC_ADDR_W-1:0]  pendAddr;
  logic [31:0]             pendData;
  logic [`EPC_ADDR_W-1:0]  rdPtr;
  logic [`EPC_ADDR_W:0]    rdLeft;
  logic                    intEn;
  logic                    doneEvt;
  logic                    badAlign;
  logic [`EPC_ADDR_W-1:0]  progWord;
  logic [`EPC_BLK_W-1:0]   progBlk;
  logic [`EPC_BLK_W-1:0]   rdBlk;
  logic                    next_intRaw;
  logic                    next_intEn;

  genvar g;
  generate
    for (g = 0; g < `EPC_BLOCKS; g++)
    begin : gGuard
      epc_block_guard uGuard
      (
        .blk0Prot   (prot[0]),
        .ownProt    (prot[g]),
        .isBlock0   (g == 0),
        .blk0Locked (locked[0]),
        .superMode  (superMode),
        .canRead    (rdOk[g]),
        .canWrite   (wrOk[g])
      );
    end
  endgenerate

  assign progWord = progAddr[`EPC_ADDR_W+1:2];
  // Block number sits just above the word-in-block bits of the array index
  // Word addresses beyond the array alias onto it; there is no range check
  assign progBlk  = progWord[WORD_W-1:WORD_W-`EPC_BLK_W];
  assign rdBlk    = rdPtr[WORD_W-1:WORD_W-`EPC_BLK_W];
  // Low address bits must be zero; misaligned addresses flag an invalid request
  assign badAlign = progAddr[1:0] != 2'h0;
  assign doneEvt  = (state != EPC_IDLE) && (timer == 8'h00);
  // Masked forms use the next raw state so they never outlive a clear
  assign next_intRaw = doneEvt ? 1'b1 : (intClear ? 1'b0 : intRaw);
  assign next_intEn  = intEnableSet ? 1'b1 : (intEnableClr ? 1'b0 : intEn);

  // Operation sequencer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= EPC_IDLE;
      timer    <= 8'h00;
      pendAddr <= '0;
      pendData <= 32'h0;
    end
    else
    begin
      unique case (state)
        EPC_IDLE:
        begin
          if (eraseStart)
          begin
            state <= EPC_ERASE;
            timer <= 8'(ERASE_CYC - 1);
          end
          else if (progStart && wrOk[progBlk] && !badAlign)
          begin
            state    <= EPC_PROG; // [RULE_09]
            timer    <= 8'(PROG_CYC - 1);
            pendAddr <= progWord;
            pendData <= progData;
          end
        end
        EPC_PROG, EPC_ERASE:
        begin
          if (timer == 8'h00)
            state <= EPC_IDLE;
          else
            timer <= timer - 8'h01;
        end
        default:
          state <= EPC_IDLE;
      endcase
    end
  end

  // Array storage; no reset so erase is the only way back to all ones
  always_ff @(posedge mclk)
  begin
    if (doneEvt && state == EPC_PROG)
      mem[pendAddr[WORD_W-1:0]] <= pendData; // [RULE_16]
    else if (doneEvt && state == EPC_ERASE)
    begin
      for (int i = 0; i < `EPC_WORDS; i++)
        mem[i] <= `EPC_ERASED_WORD; // [RULE_05]
    end
  end

  // Protection and lock state
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `EPC_BLOCKS; i++)
        prot[i] <= `EPC_PROT_RESET;
      locked <= '0;
    end
    else if (doneEvt && state == EPC_ERASE)
    begin
      for (int i = 0; i < `EPC_BLOCKS; i++)
        prot[i] <= `EPC_PROT_RESET; // [RULE_06]
      locked <= '0; // [RULE_06]
    end
    else
    begin
      if (protWrite && state == EPC_IDLE)
        prot[protBlock] <= protValue;
      if (lockWrite)
        locked[lockBlock] <= lockValue;
    end
  end

  // Status of the last operation; all zero after a clean finish
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      opStatus <= 6'h00;
    else
    begin
      if (state != EPC_IDLE && !doneEvt)
      begin
        opStatus[`EPC_ST_ACTIVE_BIT] <= 1'b1; // [RULE_10]
        opStatus[`EPC_ST_COPY_BIT]   <= state == EPC_PROG; // [RULE_10]
        opStatus[`EPC_ST_ERASE_BIT]  <= state == EPC_ERASE; // [RULE_10]
      end
      else
      begin
        opStatus[`EPC_ST_ACTIVE_BIT] <= 1'b0;
        opStatus[`EPC_ST_COPY_BIT]   <= 1'b0;
        opStatus[`EPC_ST_ERASE_BIT]  <= 1'b0;
      end
      if ((progStart || eraseStart || protWrite) && state != EPC_IDLE)
        opStatus[`EPC_ST_WRBUSY_BIT] <= 1'b1; // [RULE_11]
      else if (state == EPC_IDLE && (progStart || eraseStart))
        opStatus[`EPC_ST_WRBUSY_BIT] <= 1'b0;
      if (state == EPC_IDLE && eraseStart)
      begin
        opStatus[`EPC_ST_NOPERM_BIT] <= 1'b0; // [RULE_11]
        opStatus[`EPC_ST_INVPL_BIT]  <= 1'b0;
      end
      else if (state == EPC_IDLE && progStart)
      begin
        opStatus[`EPC_ST_NOPERM_BIT] <= !wrOk[progBlk]; // [RULE_16]
        opStatus[`EPC_ST_INVPL_BIT]  <= badAlign; // [RULE_11]
      end
      else if (state == EPC_IDLE && protWrite)
        opStatus[`EPC_ST_INVPL_BIT] <= protValue[0] && protValue[1];
    end
  end

  // Flag outputs mirror the status word
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      invalid_protect_level_flag <= 1'b0;
      write_busy_flag            <= 1'b0;
      no_permission_flag         <= 1'b0;
      copy_in_progress_flag      <= 1'b0;
      erase_in_progress_flag     <= 1'b0;
      operation_active_flag      <= 1'b0;
    end
    else
    begin
      invalid_protect_level_flag <= opStatus[`EPC_ST_INVPL_BIT];
      write_busy_flag            <= opStatus[`EPC_ST_WRBUSY_BIT];
      no_permission_flag         <= opStatus[`EPC_ST_NOPERM_BIT];
      copy_in_progress_flag      <= opStatus[`EPC_ST_COPY_BIT];
      erase_in_progress_flag     <= opStatus[`EPC_ST_ERASE_BIT];
      operation_active_flag      <= opStatus[`EPC_ST_ACTIVE_BIT];
    end
  end

  // Completion interrupt; a new completion wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intRaw         <= 1'b0;
      intEn          <= 1'b0;
      intMasked      <= 1'b0;
      flashVectorIrq <= 1'b0;
    end
    else
    begin
      if (doneEvt)
        intRaw <= 1'b1; // [RULE_01]
      else if (intClear)
        intRaw <= 1'b0; // [RULE_04]
      if (intEnableSet)
        intEn <= 1'b1;
      else if (intEnableClr)
        intEn <= 1'b0;
      intMasked      <= next_intRaw && (next_intEn || flashIntEnable); // [RULE_03]
      flashVectorIrq <= next_intRaw && (next_intEn || flashIntEnable); // [RULE_02]
    end
  end

  // Burst read, one word per cycle; refused words read as zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdPtr     <= '0;
      rdLeft    <= '0;
      readData  <= 32'h0;
      readValid <= 1'b0;
    end
    else
    begin
      if (readStart && rdLeft == '0)
      begin
        rdPtr  <= readAddr[`EPC_ADDR_W+1:2]; // [RULE_13]
        rdLeft <= (`EPC_ADDR_W+1)'(readCount[`EPC_ADDR_W+1:2]);
      end
      else if (rdLeft != '0)
      begin
        rdPtr  <= rdPtr + `EPC_ADDR_W'(1);
        rdLeft <= rdLeft - (`EPC_ADDR_W+1)'(1);
      end
      readValid <= rdLeft != '0;
      readData  <= (rdLeft != '0 && rdOk[rdBlk]) ? mem[rdPtr[WORD_W-1:0]] : 32'h0; // [RULE_14]
    end
  end

  // Capacity constant
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sizeBytes <= 32'h0;
    else
      sizeBytes <= `EPC_SIZE_BYTES; // [RULE_12]
  end
endmodule

// file: epc_ctrl_props.sv
// Port checker for the nonvolatile program and erase controller
`timescale 1ns/1ns
`include "epc_defs.svh"
module epc_ctrl_props
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        progStart,
  input wire logic        eraseStart,
  input wire logic        intClear,
  input wire logic [5:0]  opStatus,
  input wire logic        intRaw,
  input wire logic        intMasked,
  input wire logic        flashVectorIrq,
  input wire logic [31:0] sizeBytes,
  input wire logic        operation_active_flag,
  input wire logic        no_permission_flag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic idle;
  assign idle = !opStatus[5] && !eraseStart && !progStart;
  a_irq_hold: assert property (intRaw && !intClear |=> intRaw)
    else $error("interrupt dropped without clear");
  a_irq_clear: assert property (intClear && intRaw && idle |=> !intRaw)
    else $error("interrupt clear ignored");
  a_masked_raw: assert property (intMasked |-> intRaw)
    else $error("masked interrupt without raw");
  a_vector_raw: assert property (flashVectorIrq |-> intRaw)
    else $error("shared vector without raw");
  a_size_fixed: assert property ($past(rst_n) |-> sizeBytes == `EPC_SIZE_BYTES)
    else $error("capacity wrong");
  // Flags trail the status word by one cycle
  a_flag_delay: assert property (operation_active_flag == $past(opStatus[5])
    && no_permission_flag == $past(opStatus[2]))
    else $error("flags do not follow status");
  a_erase_busy: assert property (eraseStart && !opStatus[5] |=>
    ##1 opStatus[5] && opStatus[4])
    else $error("erase not active");
  a_erase_done: assert property (eraseStart && !opStatus[5] |-> ##[16:20] intRaw)
    else $error("erase finished without interrupt");
  a_rose_clean: assert property ($rose(intRaw) |-> opStatus == 6'h00)
    else $error("status not clean at completion");
  a_rose_end: assert property ($rose(intRaw) |->
    $past(opStatus[5]) || $past(opStatus[5], 2))
    else $error("interrupt without operation");
  c_erase: cover property (eraseStart ##2 opStatus[4]);
  c_masked: cover property (intMasked);
  c_refused: cover property ($rose(no_permission_flag));
endmodule
bind eeprom_program_erase_control epc_ctrl_props u_props (.mclk(mclk), .rst_n(rst_n),
  .progStart(progStart), .eraseStart(eraseStart), .intClear(intClear), .opStatus(opStatus),
  .intRaw(intRaw), .intMasked(intMasked), .flashVectorIrq(flashVectorIrq),
  .sizeBytes(sizeBytes), .operation_active_flag(operation_active_flag),
  .no_permission_flag(no_permission_flag));

// file: tb_top.sv
// Self-checking bench for the nonvolatile program and erase controller
`timescale 1ns/1ns
`include "epc_defs.svh"
module tb_top;
  logic        mclk, rst_n, superMode, progStart, eraseStart, readStart, protWrite, lockWrite;
  logic        lockValue, intEnableSet, intEnableClr, flashIntEnable, intClear;
  logic        readValid, intRaw, intMasked, flashVectorIrq;
  logic [7:0]  progAddr, readAddr, readCount;
  logic [31:0] progData, readData, sizeBytes;
  logic [1:0]  protBlock, lockBlock;
  logic [2:0]  protValue;
  logic [5:0]  opStatus;
  logic [31:0] mem [16];
  int          error_cnt, total_checks;
  int          seed;
  logic        lockModel;
  eeprom_program_erase_control dut (.mclk, .rst_n, .superMode, .progStart, .progAddr,
    .progData, .eraseStart, .readStart, .readAddr, .readCount, .protWrite, .protBlock,
    .protValue, .lockWrite, .lockBlock, .lockValue, .intEnableSet, .intEnableClr,
    .flashIntEnable, .intClear, .readData, .readValid, .opStatus, .intRaw, .intMasked,
    .flashVectorIrq, .sizeBytes, .invalid_protect_level_flag(), .write_busy_flag(),
    .no_permission_flag(), .copy_in_progress_flag(), .erase_in_progress_flag(),
    .operation_active_flag());
  always #50 mclk = ~mclk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic final_report;
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait so a lost completion cannot hang the run
  task automatic wait_irq;
    int n;
    n = 0;
    while (intRaw !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk("intRaw", intRaw, 1);
    chk("status", opStatus, 0);
  endtask
  task automatic clr;
    intClear = 1;
    tick(1);
    intClear = 0;
    tick(1);
    chk("cleared", intRaw, 0);
  endtask
  task automatic prog(input int w, input logic [31:0] d, input logic ok);
    progAddr = 8'(w * 4);
    progData = d;
    progStart = 1;
    tick(1);
    progStart = 0;
    tick(1);
    chk("active", opStatus[5], ok);
    if (ok)
    begin
      wait_irq;
      mem[w] = d;
    end
    else
    begin
      tick(8);
      chk("noPerm", opStatus[2], 1);
      chk("noIrq", intRaw, 0);
    end
  endtask
  task automatic erase;
    eraseStart = 1;
    tick(1);
    eraseStart = 0;
    tick(1);
    chk("erasing", opStatus[4], 1);
    wait_irq;
    for (int i = 0; i < 16; i++)
      mem[i] = `EPC_ERASED_WORD;
    clr;
  endtask
  task automatic rd(input int w, input int cnt);
    int k, n;
    k = w;
    n = 0;
    readAddr = 8'(w * 4);
    readCount = 8'(cnt * 4);
    readStart = 1;
    tick(1);
    readStart = 0;
    while (k < w + cnt && n < 60)
    begin
      tick(1);
      n++;
      if (readValid === 1'b1)
      begin
        chk("readData", readData, (lockModel && k >= 4) ? 32'h0 : mem[k]);
        k++;
      end
    end
    chk("words", k - w, cnt);
  endtask
  // Only block 0 locking matters; other lock bits have no effect
  task automatic lock(input logic v);
    lockBlock = 2'h0;
    lockValue = v;
    lockWrite = 1;
    tick(1);
    lockWrite = 0;
    lockModel = v;
  endtask
  task automatic setprot(input logic [1:0] b, input logic [2:0] v);
    protBlock = b;
    protValue = v;
    protWrite = 1;
    tick(1);
    protWrite = 0;
  endtask
  initial
  begin
    #(100 * 3000);
    error_cnt++;
    final_report;
  end
  initial
  begin
    int w;
    {mclk, rst_n, superMode, progStart, eraseStart, readStart, protWrite, lockWrite, lockValue,
      intEnableSet, intEnableClr, flashIntEnable, intClear, progAddr, readAddr, readCount,
      progData, protBlock, lockBlock, protValue} = '0;
    seed = 32'h11C20271;
    lockModel = 1'b0;
    tick(10);
    rst_n = 1;
    tick(1);
    chk("size", sizeBytes, `EPC_SIZE_BYTES);
    erase;
    rd(0, 16);
    intEnableSet = 1;
    tick(1);
    intEnableSet = 0;
    // Own enable, then flash-side enable, then neither
    for (int i = 0; i < 6; i++)
    begin
      w = {$random(seed)} % 16;
      prog(w, $random(seed), 1);
      chk("masked", intMasked, i < 2);
      chk("vector", flashVectorIrq, i < 2);
      clr;
      intEnableClr = 1;
      flashIntEnable = (i == 0);
      tick(1);
      intEnableClr = 0;
    end
    rd(0, 16);
    w = {$random(seed)} % 13;
    rd(w, 16 - w);
    // Block 0 locked hides the other blocks for reads and writes
    lock(1);
    prog(5, 32'h0000_0000, 0);
    rd(0, 8);
    lock(0);
    // Supervisor-only on block 2 refuses user mode and admits supervisor mode
    setprot(2'h2, 3'h4);
    prog(9, 32'h1234_5678, 0);
    superMode = 1;
    prog(9, 32'h1234_5678, 1);
    clr;
    setprot(2'h0, 3'h1);
    prog(5, 32'h0000_0000, 0);
    rd(4, 4);
    superMode = 0;
    lock(1);
    erase;
    lockModel = 1'b0;
    prog(5, 32'hA5A5_0F0F, 1);
    clr;
    rd(0, 16);
    final_report;
  end
endmodule
